/* File: pkg/fte_regs.svh */
// Purpose: offsets, fields, resets and timing counts of the frequency trip element
// Assumes: 32-bit classic wishbone, byte addresses
// Notes: cycle counts derive from the 5 ns reference clock
`ifndef FTE_REGS_SVH
`define FTE_REGS_SVH
`define FTE_CLK_PERIOD_NS 5
`define FTE_TICK_NS 1000000
`define FTE_TICK_CYC (`FTE_TICK_NS / `FTE_CLK_PERIOD_NS)
`define FTE_DEV_CYCLES 2'h3
`define FTE_OFS_CTRL 8'h00
`define FTE_OFS_SETPOINT 8'h04
`define FTE_OFS_DELAY 8'h08
`define FTE_OFS_CUTOFF 8'h0C
`define FTE_OFS_STATUS 8'h10
`define FTE_OFS_PERIOD 8'h14
`define FTE_OFS_INT_STAT 8'h18
`define FTE_OFS_INT_MASK 8'h1C
`define FTE_RST_SETPOINT 24'h30_D400
`define FTE_RST_DELAY 16'h05DC
`define FTE_RST_CUTOFF 7'h23
`define FTE_PER_MIN 24'h2B_9892
`define FTE_PER_MAX 24'h4C_4B40
`define FTE_INT_DETECT 0
`define FTE_INT_TRIP 1
`define FTE_INT_TARGET 2
`endif

/* File: pkg/fte_pkg.sv */
// Purpose: types shared by the frequency trip element
// Assumes: constants come from fte_regs.svh
// Notes: none
package fte_pkg;
  typedef enum logic [1:0] {FTE_UNDER, FTE_OVER, FTE_RESTORE, FTE_SPARE} fte_mode_e;
  typedef enum logic [1:0] {FTE_IDLE, FTE_RUN, FTE_ON, FTE_HOLD} fte_state_e;
  typedef struct packed {
    fte_mode_e mode;
    logic roc_en;
    logic [23:0] setpoint;
    logic [15:0] delay_ms;
    logic [6:0] cutoff;
  } fte_cfg_s;
  typedef struct packed {
    logic detect;
    logic timer_out;
    logic trip_target;
    logic rate_trip_target;
  } fte_ind_s;
endpackage

/* File: hw/fte_element.sv */
// Purpose: one frequency element with output timer, contacts, indicators and targets
// Assumes: all inputs synchronous to mclk_i; contact_current_i is the over-100 mA sense
// Notes: registers over classic wishbone, one aligned word each
//
// Behaviour
// R01: detect indicator rises after three consecutive deviating input cycles.
// R02: timer output indicator is high exactly while the timer drives the relay.
// R03: trip target latches on trip only when contact current exceeds 100 mA.
// R04: targets clear only by the reset switch or power removal.
// R05: over mode trips when frequency stays above setpoint beyond three cycles.
// R06: relay energizes after three-cycle detection plus the configured output delay.
// R07: undervoltage cutoff suppresses every trip output and every indicator.
// R08: losing the frequency condition drops contacts and test indicators; targets stay.
// R09: complementary normally open and normally closed contacts from the relay.
// R10: detect starts the timer only without undervoltage; delay may be zero.
// R11: rate-of-change selected bypasses delay once the lower element operated; the code bypasses in under mode only.
// R12: a setpoint outside the permitted range never operates.
// R13: restore mode uses dropout delay and enables the contact converter input.
// R14: period measured in reference cycles between input rising edges.
// R15: deviation counter clears on any non-deviating period.
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`include "fte_regs.svh"
`timescale 1ns/1ps
module fte_element
  import fte_pkg::*;
#(
  parameter int TICK_CYC = `FTE_TICK_CYC,
  parameter int AW = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic line_sq_i,
  input wire logic [6:0] volt_level_i,
  input wire logic contact_current_i,
  input wire logic target_reset_i,
  input wire logic lower_detect_i,
  input wire logic converter_i,
  output logic detect_o,
  output logic timer_output_indicator_o,
  output logic contact_no_o,
  output logic contact_nc_o,
  output logic trip_target_o,
  output logic rate_trip_target_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  fte_cfg_s cfg_reg;
  fte_ind_s ind;
  fte_state_e state_reg;
  logic [31:0] rdat_reg;
  logic [23:0] per_cnt_reg, period_reg;
  logic [17:0] tick_cnt_reg;
  logic [15:0] ms_cnt_reg;
  logic [2:0] int_stat_reg, int_mask_reg, int_set;
  logic [1:0] dev_cnt_reg;
  logic ack_reg, line_prev_reg, uv_reg, rate_hit_reg, trip_target_reg, rate_target_reg;
  logic detect_prev_reg, relay_prev_reg, rise, deviates, range_ok, detect_raw, armed;
  logic bypass, ms_tick, delay_done, relay, wr;

  // byte-enable merge of a write into a stored word
  function automatic logic [31:0] fte_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // configuration registers
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_reg.mode <= FTE_UNDER;
      cfg_reg.roc_en <= 1'b0;
      cfg_reg.setpoint <= `FTE_RST_SETPOINT;
      cfg_reg.delay_ms <= `FTE_RST_DELAY;
      cfg_reg.cutoff <= `FTE_RST_CUTOFF;
      int_mask_reg <= 3'h0;
    end else if (wr) begin
      case (wb_adr_i)
        `FTE_OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            cfg_reg.mode <= fte_mode_e'(wb_dat_i[1:0]);
            cfg_reg.roc_en <= wb_dat_i[2];
          end
        end
        `FTE_OFS_SETPOINT: cfg_reg.setpoint <= 24'(fte_merge({8'h00, cfg_reg.setpoint}, wb_dat_i, wb_sel_i));
        `FTE_OFS_DELAY: cfg_reg.delay_ms <= 16'(fte_merge({16'h0000, cfg_reg.delay_ms}, wb_dat_i, wb_sel_i));
        `FTE_OFS_CUTOFF: cfg_reg.cutoff <= 7'(fte_merge({25'h0, cfg_reg.cutoff}, wb_dat_i, wb_sel_i));
        `FTE_OFS_INT_MASK: int_mask_reg <= 3'(fte_merge({29'h0, int_mask_reg}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // read data, unmapped reads as zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdat_reg <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        `FTE_OFS_CTRL: rdat_reg <= {29'h0, cfg_reg.roc_en, cfg_reg.mode};
        `FTE_OFS_SETPOINT: rdat_reg <= {8'h00, cfg_reg.setpoint};
        `FTE_OFS_DELAY: rdat_reg <= {16'h0000, cfg_reg.delay_ms};
        `FTE_OFS_CUTOFF: rdat_reg <= {25'h0, cfg_reg.cutoff};
        `FTE_OFS_STATUS: rdat_reg <= {26'h0, !range_ok, uv_reg, ind};
        `FTE_OFS_PERIOD: rdat_reg <= {8'h00, period_reg};
        `FTE_OFS_INT_STAT: rdat_reg <= {29'h0, int_stat_reg};
        `FTE_OFS_INT_MASK: rdat_reg <= {29'h0, int_mask_reg};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // period measurement
  assign rise = line_sq_i && !line_prev_reg;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      line_prev_reg <= 1'b0;
      per_cnt_reg <= 24'h00_0000;
      period_reg <= 24'h00_0000;
    end else begin
      line_prev_reg <= line_sq_i;
      if (rise) begin
        period_reg <= per_cnt_reg; // see R14
        per_cnt_reg <= 24'h00_0001;
      end else if (per_cnt_reg != 24'hFF_FFFF) begin
        per_cnt_reg <= per_cnt_reg + 24'h00_0001;
      end
    end
  end

  // deviation in the configured direction: long period is under, short is over
  assign deviates = (cfg_reg.mode == FTE_UNDER) ? (per_cnt_reg > cfg_reg.setpoint) :
                    (per_cnt_reg < cfg_reg.setpoint); // see R05
  assign range_ok = (cfg_reg.setpoint >= `FTE_PER_MIN) && (cfg_reg.setpoint <= `FTE_PER_MAX) &&
                    (cfg_reg.mode != FTE_SPARE);

  // consecutive deviating cycles, saturating at three
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      dev_cnt_reg <= 2'h0;
    end else if (rise) begin
      if (!deviates) begin
        dev_cnt_reg <= 2'h0; // see R15
      end else if (dev_cnt_reg != `FTE_DEV_CYCLES) begin
        dev_cnt_reg <= dev_cnt_reg + 2'h1; // see R01
      end
    end
  end

  // undervoltage supervision
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_reg <= 1'b1;
    end else begin
      uv_reg <= volt_level_i < cfg_reg.cutoff;
    end
  end

  // detect, gated by range, converter input in restore, and cutoff
  assign detect_raw = (dev_cnt_reg == `FTE_DEV_CYCLES) && range_ok && // see R01 R12
                      ((cfg_reg.mode != FTE_RESTORE) || converter_i); // see R13
  assign armed = detect_raw && !uv_reg; // see R10
  assign bypass = cfg_reg.roc_en && (cfg_reg.mode == FTE_UNDER) && lower_detect_i; // see R11

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick and output timer
  assign ms_tick = tick_cnt_reg == 18'(TICK_CYC - 1);
  assign delay_done = ms_cnt_reg >= cfg_reg.delay_ms;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_reg <= 18'h0_0000;
    end else if (state_reg == FTE_RUN || state_reg == FTE_HOLD) begin
      tick_cnt_reg <= ms_tick ? 18'h0_0000 : tick_cnt_reg + 18'h0_0001;
    end else begin
      tick_cnt_reg <= 18'h0_0000;
    end
  end

  // timer state: pickup delay, or dropout delay in restore mode
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= FTE_IDLE;
      ms_cnt_reg <= 16'h0000;
      rate_hit_reg <= 1'b0;
    end else begin
      case (state_reg)
        FTE_IDLE: begin
          ms_cnt_reg <= 16'h0000;
          rate_hit_reg <= 1'b0;
          if (armed) begin
            if (cfg_reg.mode == FTE_RESTORE || cfg_reg.delay_ms == 16'h0000) begin
              state_reg <= FTE_ON; // see R10 R13
            end else if (bypass) begin
              state_reg <= FTE_ON; // see R11
              rate_hit_reg <= 1'b1;
            end else begin
              state_reg <= FTE_RUN;
            end
          end
        end
        FTE_RUN: begin
          if (!armed) begin
            state_reg <= FTE_IDLE; // see R08
          end else if (bypass) begin
            state_reg <= FTE_ON; // see R11
            rate_hit_reg <= 1'b1;
          end else if (delay_done) begin
            state_reg <= FTE_ON; // see R06
          end else if (ms_tick) begin
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
          end
        end
        FTE_ON: begin
          ms_cnt_reg <= 16'h0000;
          if (uv_reg) begin
            state_reg <= FTE_IDLE; // see R07
          end else if (!armed) begin
            state_reg <= (cfg_reg.mode == FTE_RESTORE && cfg_reg.delay_ms != 16'h0000) ? FTE_HOLD :
                         FTE_IDLE; // see R08 R13
          end
        end
        FTE_HOLD: begin
          if (uv_reg) begin
            state_reg <= FTE_IDLE; // see R07
          end else if (armed) begin
            state_reg <= FTE_ON;
          end else if (delay_done) begin
            state_reg <= FTE_IDLE; // see R13
          end else if (ms_tick) begin
            ms_cnt_reg <= ms_cnt_reg + 16'h0001;
          end
        end
        default: state_reg <= FTE_IDLE;
      endcase
    end
  end

  assign relay = (state_reg == FTE_ON || state_reg == FTE_HOLD) && !uv_reg; // see R07

  ////////////////////////////////////////////////////////////////////////
  // latched targets, set wins over the reset switch
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      trip_target_reg <= 1'b0;
      rate_target_reg <= 1'b0;
    end else begin
      if (relay && contact_current_i) begin
        trip_target_reg <= 1'b1; // see R03
      end else if (target_reset_i) begin
        trip_target_reg <= 1'b0; // see R04
      end
      if (relay && rate_hit_reg && contact_current_i) begin
        rate_target_reg <= 1'b1; // see R03
      end else if (target_reset_i) begin
        rate_target_reg <= 1'b0; // see R04
      end
    end
  end

  // indicators and contacts
  assign ind.detect = armed; // see R07 R08
  assign ind.timer_out = relay; // see R02
  assign ind.trip_target = trip_target_reg && !uv_reg; // see R07
  assign ind.rate_trip_target = rate_target_reg && !uv_reg;
  assign detect_o = ind.detect;
  assign timer_output_indicator_o = ind.timer_out;
  assign contact_no_o = relay; // see R09
  assign contact_nc_o = !relay; // see R09
  assign trip_target_o = ind.trip_target;
  assign rate_trip_target_o = ind.rate_trip_target;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, set wins
  assign int_set = {relay && contact_current_i && !trip_target_reg, relay && !relay_prev_reg,
                    armed && !detect_prev_reg};

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      int_stat_reg <= 3'h0;
      detect_prev_reg <= 1'b0;
      relay_prev_reg <= 1'b0;
    end else begin
      detect_prev_reg <= armed;
      relay_prev_reg <= relay;
      if (wr && wb_adr_i == `FTE_OFS_INT_STAT && wb_sel_i[0]) begin
        int_stat_reg <= (int_stat_reg & ~wb_dat_i[2:0]) | int_set;
      end else begin
        int_stat_reg <= int_stat_reg | int_set;
      end
    end
  end

  assign irq_o = |(int_stat_reg & int_mask_reg);

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_trip_cond;
    contact_no_o && contact_current_i;
  endsequence
  sequence s_zero_pick;
    state_reg == FTE_IDLE && armed && cfg_reg.delay_ms == 16'h0000;
  endsequence

  property p_detect;
    @(posedge mclk_i) disable iff (reset_i) detect_o |-> dev_cnt_reg == 2'h3 && !uv_reg;
  endproperty
  a_detect: assert property (p_detect) else $error("detect without three cycles"); // see R01
  property p_tb;
    @(posedge mclk_i) disable iff (reset_i) timer_output_indicator_o == contact_no_o;
  endproperty
  a_tb: assert property (p_tb) else $error("timer indicator differs from relay"); // see R02
  property p_target_set;
    @(posedge mclk_i) disable iff (reset_i) s_trip_cond |=> trip_target_reg;
  endproperty
  a_target_set: assert property (p_target_set) else $error("target not latched"); // see R03
  property p_target_hold;
    @(posedge mclk_i) disable iff (reset_i) trip_target_reg && !target_reset_i |=> trip_target_reg;
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("target dropped"); // see R04
  property p_delay;
    @(posedge mclk_i) disable iff (reset_i)
      state_reg == FTE_RUN && armed && !bypass && !delay_done |=> !contact_no_o;
  endproperty
  a_delay: assert property (p_delay) else $error("relay before delay"); // see R06 R05
  property p_uv;
    @(posedge mclk_i) disable iff (reset_i) uv_reg |-> !contact_no_o && !detect_o && !trip_target_o;
  endproperty
  a_uv: assert property (p_uv) else $error("output under cutoff"); // see R07
  property p_release;
    @(posedge mclk_i) disable iff (reset_i)
      contact_no_o && !armed && cfg_reg.mode != FTE_RESTORE |=> !contact_no_o && !detect_o;
  endproperty
  a_release: assert property (p_release) else $error("relay held after condition"); // see R08
  property p_nc;
    @(posedge mclk_i) disable iff (reset_i) contact_nc_o != contact_no_o;
  endproperty
  a_nc: assert property (p_nc) else $error("contacts not complementary"); // see R09
  property p_zero;
    @(posedge mclk_i) disable iff (reset_i) s_zero_pick ##1 !uv_reg |-> contact_no_o;
  endproperty
  a_zero: assert property (p_zero) else $error("zero delay not immediate"); // see R10
  property p_bypass;
    @(posedge mclk_i) disable iff (reset_i)
      state_reg == FTE_RUN && armed && bypass ##1 !uv_reg |-> contact_no_o && rate_hit_reg;
  endproperty
  a_bypass: assert property (p_bypass) else $error("rate bypass missed"); // see R11
  property p_range;
    @(posedge mclk_i) disable iff (reset_i) !range_ok |-> !detect_o;
  endproperty
  a_range: assert property (p_range) else $error("out of range operated"); // see R12
  property p_restore;
    @(posedge mclk_i) disable iff (reset_i)
      cfg_reg.mode == FTE_RESTORE && state_reg == FTE_ON && !armed && !uv_reg && cfg_reg.delay_ms != 16'h0000
      |=> state_reg == FTE_HOLD;
  endproperty
  a_restore: assert property (p_restore) else $error("no dropout delay"); // see R13
  property p_period;
    @(posedge mclk_i) disable iff (reset_i) rise |=> period_reg == $past(per_cnt_reg);
  endproperty
  a_period: assert property (p_period) else $error("period not captured"); // see R14
  property p_devclr;
    @(posedge mclk_i) disable iff (reset_i) rise && !deviates |=> dev_cnt_reg == 2'h0;
  endproperty
  a_devclr: assert property (p_devclr) else $error("deviation count kept"); // see R15

endmodule // fte_element

/* File: bench/fte_line_model.sv */
// Purpose: line voltage source and breaker trip circuit facing the element
// Assumes: half period is given in reference clocks
// Notes: the line rests low while stopped, so no stray edges appear
`timescale 1ns/1ps
module fte_line_model (
  input wire logic mclk_i,
  input wire logic run_i,
  input wire logic [15:0] half_i,
  input wire logic breaker_i,
  input wire logic contact_no_i,
  output logic line_sq_o,
  output logic contact_current_o
);
  logic [15:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // square wave, toggles every half_i clocks while running
  always_ff @(posedge mclk_i) begin
    if (!run_i) begin
      cnt_reg <= 16'h0000;
      line_sq_o <= 1'b0;
    end else if (cnt_reg + 16'h0001 >= half_i) begin
      cnt_reg <= 16'h0000;
      line_sq_o <= ~line_sq_o;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // trip current flows only through a closed breaker circuit
  assign contact_current_o = breaker_i & contact_no_i;
endmodule // fte_line_model

/* File: bench/fte_element_bench.sv */
// Purpose: self-checking bench of the frequency trip element
// Assumes: short timer tick; over and restore modes use short line periods
// Notes: long under-frequency periods are left to the design's own assertions
`timescale 1ns/1ps
`include "fte_regs.svh"
module fte_element_bench
  import fte_pkg::*;
#(
  parameter int TICK = 20
);
  localparam int DET = 0, NO = 1, TBI = 2, NC = 3, TGT = 4, RTG = 5, IRQ = 6;
  logic mclk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run, breaker, line_sq, cur, line_d;
  logic target_reset_i, converter_i, detect_o, timer_output_indicator_o, contact_no_o, contact_nc_o;
  logic trip_target_o, rate_trip_target_o, irq_o, lower;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [6:0] volt_level_i, outs;
  logic [15:0] half;
  int bad_count, check_count, rise_n;

  assign outs = {irq_o, rate_trip_target_o, trip_target_o, contact_nc_o, timer_output_indicator_o, contact_no_o,
                 detect_o};

  fte_element #(.TICK_CYC(TICK)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_sq_i(line_sq), .volt_level_i(volt_level_i),
    .contact_current_i(cur), .target_reset_i(target_reset_i), .lower_detect_i(lower),
    .converter_i(converter_i), .detect_o(detect_o), .timer_output_indicator_o(timer_output_indicator_o),
    .contact_no_o(contact_no_o), .contact_nc_o(contact_nc_o), .trip_target_o(trip_target_o),
    .rate_trip_target_o(rate_trip_target_o), .irq_o(irq_o));

  fte_line_model line_side (.mclk_i(mclk_i), .run_i(run), .half_i(half), .breaker_i(breaker),
    .contact_no_i(contact_no_o), .line_sq_o(line_sq), .contact_current_o(cur));

  ////////////////////////////////////////////////////////////////////////////
  // clock and rising-edge count of the line
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    line_d <= line_sq;
    if (!run) rise_n <= 0;
    else if (line_sq && !line_d) rise_n <= rise_n + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparison, verdict and bus helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    // wait for ack; only the watchdog ends a hung cycle
    do begin
      @(posedge mclk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    wb(1'b1, a, d, t);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    wb(1'b0, a, 32'h0000_0000, t);
    check(t, exp);
  endtask

  // bounded wait for one output to reach a level, then judge it
  task automatic wait_bit(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[k] !== v && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
    check(32'(outs[k]), 32'(v));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_values();
    rd_chk(`FTE_OFS_CTRL, 32'h0000_0000);
    rd_chk(`FTE_OFS_SETPOINT, 32'(`FTE_RST_SETPOINT));
    rd_chk(`FTE_OFS_DELAY, 32'(`FTE_RST_DELAY));
    rd_chk(`FTE_OFS_CUTOFF, 32'(`FTE_RST_CUTOFF));
    rd_chk(`FTE_OFS_INT_MASK, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0000_0000);
    wr(`FTE_OFS_STATUS, 32'h0000_003F);
    rd_chk(`FTE_OFS_STATUS, 32'h0000_0000);
  endtask

  task automatic t_over_trip();
    wr(`FTE_OFS_DELAY, 32'h0000_0002);
    wr(`FTE_OFS_CTRL, 32'h0000_0005);
    lower <= 1'b1;
    run <= 1'b1;
    wait_bit(DET, 1'b1, 200);
    check(32'(rise_n), 32'h0000_0003);
    rd_chk(`FTE_OFS_PERIOD, 32'h0000_0014);
    repeat (2 * TICK - 10) @(posedge mclk_i);
    check(32'(outs[NO]), 32'h0000_0000);
    wait_bit(NO, 1'b1, 30);
    check(32'(outs[TBI]), 32'h0000_0001);
    check(32'(outs[NC]), 32'h0000_0000);
    repeat (4) @(posedge mclk_i);
    check(32'(outs[TGT]), 32'h0000_0000);
    check(32'(outs[IRQ]), 32'h0000_0000);
    breaker <= 1'b1;
    wait_bit(TGT, 1'b1, 4);
    check(32'(outs[RTG]), 32'h0000_0000);
    rd_chk(`FTE_OFS_INT_STAT, 32'h0000_0007);
    wr(`FTE_OFS_INT_MASK, 32'h0000_0007);
    wait_bit(IRQ, 1'b1, 3);
    wr(`FTE_OFS_INT_STAT, 32'h0000_0007);
    rd_chk(`FTE_OFS_INT_STAT, 32'h0000_0000);
    wait_bit(IRQ, 1'b0, 3);
  endtask

  task automatic t_loss();
    wr(`FTE_OFS_CTRL, 32'(FTE_UNDER));
    wait_bit(DET, 1'b0, 40);
    wait_bit(NO, 1'b0, 3);
    check(32'(outs[TBI]), 32'h0000_0000);
    check(32'(outs[TGT]), 32'h0000_0001);
    @(posedge mclk_i);
    target_reset_i <= 1'b1;
    @(posedge mclk_i);
    target_reset_i <= 1'b0;
    wait_bit(TGT, 1'b0, 3);
  endtask

  task automatic t_uv();
    @(posedge mclk_i);
    volt_level_i <= 7'h5E;
    wr(`FTE_OFS_CUTOFF, 32'h0000_005F);
    wr(`FTE_OFS_DELAY, 32'h0000_0000);
    wr(`FTE_OFS_CTRL, 32'(FTE_OVER));
    repeat (100) @(posedge mclk_i);
    check(32'(outs), 32'h0000_0008);
    volt_level_i <= 7'h5F;
    wait_bit(NO, 1'b1, 10);
    wait_bit(TGT, 1'b1, 4);
    volt_level_i <= 7'h5E;
    wait_bit(TGT, 1'b0, 4);
    check(32'(outs[NO]), 32'h0000_0000);
    check(32'(outs[DET]), 32'h0000_0000);
    wr(`FTE_OFS_CUTOFF, 32'(`FTE_RST_CUTOFF));
    volt_level_i <= 7'h64;
    wr(`FTE_OFS_SETPOINT, 32'h0000_0100);
    target_reset_i <= 1'b1;
    repeat (100) @(posedge mclk_i);
    check(32'(outs[DET]), 32'h0000_0000);
    check(32'(outs[NO]), 32'h0000_0000);
    check(32'(outs[TGT]), 32'h0000_0000);
    target_reset_i <= 1'b0;
    wr(`FTE_OFS_SETPOINT, 32'(`FTE_RST_SETPOINT));
  endtask

  task automatic t_restore();
    @(posedge mclk_i);
    converter_i <= 1'b0;
    wr(`FTE_OFS_DELAY, 32'h0000_0001);
    wr(`FTE_OFS_CTRL, 32'(FTE_RESTORE));
    repeat (TICK + 40) @(posedge mclk_i);
    check(32'(outs[DET]), 32'h0000_0000);
    converter_i <= 1'b1;
    wait_bit(DET, 1'b1, 50);
    wait_bit(NO, 1'b1, 3);
    converter_i <= 1'b0;
    wait_bit(DET, 1'b0, 5);
    repeat (TICK / 2) @(posedge mclk_i);
    check(32'(outs[NO]), 32'h0000_0001);
    wait_bit(NO, 1'b0, TICK + 5);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    reset_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    volt_level_i = 7'h64;
    target_reset_i = 1'b0;
    converter_i = 1'b0;
    run = 1'b0;
    breaker = 1'b0;
    half = 16'h000A;
    lower = 1'b0;
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_reset_values();
    t_over_trip();
    t_loss();
    t_uv();
    t_restore();
    give_verdict();
  end

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule // fte_element_bench
